// File: gpt_evp_dev.sv
/*
  Device end: main control registers, group power-up and init, PCM bypass
  in power down, and the tone interrupt queue with its pin.
  Assumes the host keeps the reset, lock-wait and init-wait timing.
*/
`timescale 1ns/1ps
module gpt_evp_dev #(
  parameter int FRAME_CYC  = gpt_pkg::FRAME_CYC,
  parameter int FIFO_DEPTH = gpt_pkg::FIFO_DEPTH
) (
  input  logic        clk,
  input  logic        reset,
  gpt_link_if.dev     link,
  input  logic [31:0] tone_detect,
  input  logic        pcm_valid,
  input  logic [4:0]  pcm_chan,
  input  logic [7:0]  rin_in,
  input  logic [7:0]  sin_in,
  input  logic [7:0]  proc_rout,
  input  logic [7:0]  proc_sout,
  output logic [7:0]  rout,
  output logic [7:0]  sout,
  output logic        pcm_out_valid,
  output logic        pcm_out_en,
  output logic [15:0] group_active,
  output logic [15:0] coef_clear
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0][7:0]        main;
    logic [7:0]              test;
    logic [31:0][1:0][7:0]   ctl;
    logic [15:0][1:0]        init_left;
    logic [15:0]             gact;
    logic [15:0]             coef;
    logic [31:0]             tone;
    logic [31:0]             pend_on;
    logic [31:0]             pend_off;
    logic [15:0]             frame_cnt;
    logic [7:0]              dout;
    logic                    dout_oe;
    logic                    ack_n;
    logic                    ack_oe;
    logic                    irq_n;
    logic                    irq_oe;
    logic [31:0][1:0][15:0]  dly;
    logic [7:0]              rout;
    logic [7:0]              sout;
    logic                    out_v;
    logic                    out_en;
  } gpt_dev_st_t;

  gpt_dev_st_t s_q;
  gpt_dev_st_t s_d;
  logic        rst;
  logic        fifo_in_v;
  logic        fifo_in_rdy;
  logic [4:0]  fifo_in_d;
  logic        fifo_out_v;
  logic        fifo_pop;
  logic [4:0]  fifo_out_d;

  // Host reset pin and system reset both hold the device down
  assign rst = reset | ~link.reset_n;

  // ----------------------------------------------------------------
  // Interrupt queue
  // ----------------------------------------------------------------
  gpt_irq_fifo #(
    .W     (5),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .reset     (rst),
    .in_valid  (fifo_in_v),
    .in_ready  (fifo_in_rdy),
    .in_data   (fifo_in_d),
    .out_valid (fifo_out_v),
    .out_ready (fifo_pop),
    .out_data  (fifo_out_d)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [31:0] rise;
    logic [31:0] fall;
    logic [31:0] on_clr;
    logic [31:0] off_clr;
    logic        blk;
    logic [4:0]  pk;
    logic [4:0]  bch;
    logic [3:0]  bg;
    logic [3:0]  mi;
    logic [3:0]  pg;
    rise      = '0;
    fall      = '0;
    on_clr    = '0;
    off_clr   = '0;
    blk       = 1'b0;
    pk        = '0;
    bch       = link.addr[9:5];
    bg        = link.addr[9:6];
    mi        = link.addr[3:0];
    pg        = pcm_chan[4:1];
    s_d       = s_q;
    fifo_in_v = 1'b0;
    fifo_in_d = '0;
    fifo_pop  = 1'b0;

    // Tone edges per channel, gated by global and per-canceller masks
    s_d.tone = tone_detect;
    for (int i = 0; i < gpt_pkg::N_CH; i++) begin
      blk = s_q.main[0][gpt_pkg::B_GMASK]
          | s_q.main[i >> 1][((i & 1) != 0) ? gpt_pkg::B_MASK_B : gpt_pkg::B_MASK_A];
      rise[i] = tone_detect[i] & ~s_q.tone[i] & ~blk;
      fall[i] = ~tone_detect[i] & s_q.tone[i] & ~blk;
    end

    // Lowest pending channel goes into the queue, one entry per cycle
    for (int i = gpt_pkg::N_CH - 1; i >= 0; i--) begin
      if (s_q.pend_on[i] | s_q.pend_off[i]) begin
        fifo_in_v = 1'b1;
        pk        = 5'(i);
      end
    end
    fifo_in_d = pk;
    if (fifo_in_v & fifo_in_rdy) begin
      if (s_q.pend_on[pk]) begin
        on_clr[pk] = 1'b1;
      end else begin
        off_clr[pk] = 1'b1;
      end
    end
    // New edge wins over the clear of the same pending bit
    s_d.pend_on  = (s_q.pend_on & ~on_clr) | rise;
    s_d.pend_off = (s_q.pend_off & ~off_clr) | fall;

    // Frame divider and init countdown
    if (s_q.frame_cnt == 16'(FRAME_CYC - 1)) begin
      s_d.frame_cnt = '0;
      for (int j = 0; j < gpt_pkg::N_GRP; j++) begin
        if (s_q.init_left[j] != '0) begin
          s_d.init_left[j] = s_q.init_left[j] - 2'd1;
        end
      end
    end else begin
      s_d.frame_cnt = s_q.frame_cnt + 16'h0001;
    end

    // Register access; read data stands in the cycle after the strobe
    s_d.dout    = '0;
    s_d.dout_oe = link.rd;
    s_d.ack_n   = ~(link.rd | link.wr);
    s_d.ack_oe  = 1'b1;
    s_d.irq_oe  = 1'b1;
    s_d.out_en  = 1'b1;
    if (link.addr < gpt_pkg::A_MAIN) begin
      if (link.rd) begin
        case (link.addr[4:0])
          gpt_pkg::OFF_CTRL1: s_d.dout = s_q.ctl[bch][0];
          gpt_pkg::OFF_CTRL2: s_d.dout = s_q.ctl[bch][1];
          gpt_pkg::OFF_STAT:  s_d.dout[gpt_pkg::B_TD] = s_q.tone[bch];
          default:            s_d.dout = '0;
        endcase
      end
      // Group registers are locked while the group initialises
      if (link.wr && s_q.init_left[bg] == '0) begin
        case (link.addr[4:0])
          gpt_pkg::OFF_CTRL1: s_d.ctl[bch][0] = link.wdata;
          gpt_pkg::OFF_CTRL2: s_d.ctl[bch][1] = link.wdata;
          default:            s_d.ctl[bch] = s_q.ctl[bch];
        endcase
      end
    end else if (link.addr[15:4] == gpt_pkg::A_MAIN[15:4]) begin
      if (link.rd) begin
        s_d.dout = s_q.main[mi];
      end
      if (link.wr) begin
        s_d.main[mi] = link.wdata;
        if (link.wdata[gpt_pkg::B_GROUP_POWER_UP_BIT] & ~s_q.main[mi][gpt_pkg::B_GROUP_POWER_UP_BIT]) begin
          s_d.init_left[mi]          = 2'(gpt_pkg::INIT_FRAMES);
          s_d.ctl[{mi, 1'b0}][0]     = gpt_pkg::CTRL1_DEF;
          s_d.ctl[{mi, 1'b0}][1]     = gpt_pkg::CTRL2_DEF;
          s_d.ctl[{mi, 1'b1}][0]     = gpt_pkg::CTRL1_DEF;
          s_d.ctl[{mi, 1'b1}][1]     = gpt_pkg::CTRL2_DEF;
        end
        if (~link.wdata[gpt_pkg::B_GROUP_POWER_UP_BIT]) begin
          s_d.init_left[mi] = '0;
        end
      end
    end else if (link.addr == gpt_pkg::A_FIFO) begin
      if (link.rd) begin
        fifo_pop = fifo_out_v;
        s_d.dout = fifo_out_v ? (gpt_pkg::FIFO_VLD | 8'(fifo_out_d)) : '0;
      end
    end else if (link.addr == gpt_pkg::A_TEST) begin
      if (link.rd) begin
        s_d.dout = s_q.test;
      end
      if (link.wr) begin
        s_d.test = link.wdata;
      end
    end

    // Group state: active after init, coefficients held clear during it
    for (int j = 0; j < gpt_pkg::N_GRP; j++) begin
      s_d.gact[j] = s_d.main[j][gpt_pkg::B_GROUP_POWER_UP_BIT] & (s_d.init_left[j] == '0);
      s_d.coef[j] = s_d.init_left[j] != '0;
    end

    // Pin high in the cycle after a FIFO read, low again while entries wait
    s_d.irq_n = ~(fifo_out_v & ~fifo_pop & ~s_q.main[0][gpt_pkg::B_GMASK]);

    // PCM: two-frame delay line per channel, used while the group is down
    s_d.out_v = pcm_valid;
    if (pcm_valid) begin
      s_d.dly[pcm_chan][0] = {rin_in, sin_in};
      s_d.dly[pcm_chan][1] = s_q.dly[pcm_chan][0];
      if (s_q.gact[pg]) begin
        s_d.rout = proc_rout;
        s_d.sout = proc_sout;
      end else begin
        {s_d.rout, s_d.sout} = s_q.dly[pcm_chan][1];
      end
    end
  end

  // ----------------------------------------------------------------
  // State register; reset zeroes registers and releases every pin
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs
  assign link.dout               = s_q.dout;
  assign link.dout_oe            = s_q.dout_oe;
  assign link.transfer_ack_out_n = s_q.ack_n;
  assign link.ack_oe             = s_q.ack_oe;
  assign link.irq_n_out          = s_q.irq_n;
  assign link.irq_oe             = s_q.irq_oe;
  assign rout                    = s_q.rout;
  assign sout                    = s_q.sout;
  assign pcm_out_valid           = s_q.out_v;
  assign pcm_out_en              = s_q.out_en;
  assign group_active            = s_q.gact;
  assign coef_clear              = s_q.coef;
endmodule : gpt_evp_dev

// File: gpt_host_ctl.sv
/*
  Host end: power-up sequencer, interrupt service, manual access and call
  init, driven by a small software register port.
  Assumes the device answers reads in the cycle after the strobe.
*/
`timescale 1ns/1ps
module gpt_host_ctl #(
  parameter int PLL_WAIT_CYC  = gpt_pkg::PLL_WAIT_CYC,
  parameter int INIT_WAIT_CYC = gpt_pkg::INIT_WAIT_CYC
) (
  input  logic        clk,
  input  logic        reset,
  gpt_link_if.host    link,
  input  logic [3:0]  sw_addr,
  input  logic [15:0] sw_wdata,
  input  logic        sw_wr,
  input  logic        sw_rd,
  output logic [15:0] sw_rdata,
  output logic        irq
);
  typedef enum logic [3:0] {
    st_idle, st_rst, st_pll, st_pwr, st_init, st_strb, st_capt,
    st_irq1, st_irq2, st_man, st_callw, st_calle
  } gpt_hfsm_t;

  typedef struct packed {
    gpt_hfsm_t   fsm;
    gpt_hfsm_t   ret;
    logic [15:0] cnt;
    logic [4:0]  grp;
    logic [3:0]  cmd;
    logic [15:0] groups;
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    logic [7:0]  last;
    logic [4:0]  call_ch;
    logic [3:0]  stat;
    logic [3:0]  mask;
    logic        up;
    logic        rdop;
    logic        rst_n;
    logic        wr;
    logic        rd;
    logic [15:0] la;
    logic [7:0]  lw;
    logic [15:0] swr;
    logic        irq;
  } gpt_hst_t;

  gpt_hst_t s_q;
  gpt_hst_t s_d;

  // Start one link access; the answer is taken two cycles on
  function automatic gpt_hst_t issue(input gpt_hst_t s, input logic w,
                                     input logic [15:0] a, input logic [7:0] d,
                                     input gpt_hfsm_t r);
    gpt_hst_t t;
    t      = s;
    t.wr   = w;
    t.rd   = ~w;
    t.rdop = ~w;
    t.la   = a;
    t.lw   = d;
    t.ret  = r;
    t.fsm  = st_strb;
    return t;
  endfunction : issue

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [3:0] set;
    logic [3:0] w1c;
    set = '0;
    w1c = '0;
    s_d = s_q;

    // Software port
    if (sw_wr) begin
      case (sw_addr)
        gpt_pkg::H_CTRL:   s_d.cmd = s_q.cmd | sw_wdata[3:0];
        gpt_pkg::H_GROUPS: s_d.groups = sw_wdata;
        gpt_pkg::H_ADDR:   s_d.addr = sw_wdata;
        gpt_pkg::H_WDATA:  s_d.wdata = sw_wdata[7:0];
        gpt_pkg::H_STAT:   w1c = sw_wdata[3:0];
        gpt_pkg::H_MASK:   s_d.mask = sw_wdata[3:0];
        gpt_pkg::H_CALL:   s_d.call_ch = sw_wdata[4:0];
        default:           s_d.cmd = s_d.cmd;
      endcase
    end
    s_d.swr = '0;
    if (sw_rd) begin
      case (sw_addr)
        gpt_pkg::H_GROUPS: s_d.swr = s_q.groups;
        gpt_pkg::H_ADDR:   s_d.swr = s_q.addr;
        gpt_pkg::H_WDATA:  s_d.swr = {8'h00, s_q.wdata};
        gpt_pkg::H_RDATA:  s_d.swr = {8'h00, s_q.rdata};
        gpt_pkg::H_STAT:   s_d.swr = {12'h000, s_q.stat};
        gpt_pkg::H_MASK:   s_d.swr = {12'h000, s_q.mask};
        gpt_pkg::H_LAST:   s_d.swr = {8'h00, s_q.last};
        gpt_pkg::H_CALL:   s_d.swr = {11'h000, s_q.call_ch};
        gpt_pkg::H_STATE:  s_d.swr = {7'h00, s_q.up, s_q.cmd, s_q.fsm};
        default:           s_d.swr = '0;
      endcase
    end

    // Sequencer
    case (s_q.fsm)
      st_idle: begin
        if (s_q.cmd[gpt_pkg::C_SEQ]) begin
          s_d.cmd[gpt_pkg::C_SEQ] = 1'b0;
          s_d.rst_n = 1'b0;
          s_d.up    = 1'b0;
          s_d.cnt   = '0;
          s_d.fsm   = st_rst;
        end else if (s_q.up && !link.irq_n) begin
          s_d = issue(s_d, 1'b0, gpt_pkg::A_FIFO, 8'h00, st_irq1);
        end else if (s_q.cmd[gpt_pkg::C_RD] | s_q.cmd[gpt_pkg::C_WR]) begin
          s_d.cmd[gpt_pkg::C_RD] = 1'b0;
          s_d.cmd[gpt_pkg::C_WR] = 1'b0;
          s_d = issue(s_d, s_q.cmd[gpt_pkg::C_WR], s_q.addr, s_q.wdata, st_man);
        end else if (s_q.cmd[gpt_pkg::C_CALL]) begin
          s_d.cmd[gpt_pkg::C_CALL] = 1'b0;
          s_d.cnt = '0;
          s_d = issue(s_d, 1'b1, {6'h00, s_q.call_ch, gpt_pkg::OFF_CTRL1},
                      gpt_pkg::CTRL1_BYP, st_callw);
        end
      end
      st_rst: begin
        s_d.cnt = s_q.cnt + 16'h0001;
        if (s_q.cnt == 16'(gpt_pkg::RST_HOLD_CYC - 1)) begin
          s_d.rst_n = 1'b1;
          s_d.cnt   = '0;
          s_d.fsm   = st_pll;
        end
      end
      st_pll: begin
        s_d.cnt = s_q.cnt + 16'h0001;
        if (s_q.cnt == 16'(PLL_WAIT_CYC - 1)) begin
          s_d.grp = '0;
          s_d.fsm = st_pwr;
        end
      end
      st_pwr: begin
        s_d.grp = s_q.grp + 5'h01;
        if (s_q.grp == 5'(gpt_pkg::N_GRP)) begin
          s_d.cnt = '0;
          s_d.fsm = st_init;
        end else if (s_q.groups[s_q.grp[3:0]]) begin
          s_d = issue(s_d, 1'b1, {gpt_pkg::A_MAIN[15:4], s_q.grp[3:0]},
                      8'h01 << gpt_pkg::B_GROUP_POWER_UP_BIT, st_pwr);
        end
      end
      st_init: begin
        s_d.cnt = s_q.cnt + 16'h0001;
        if (s_q.cnt == 16'(INIT_WAIT_CYC - 1)) begin
          s_d.up = 1'b1;
          set[gpt_pkg::S_SEQ] = 1'b1;
          s_d.fsm = st_idle;
        end
      end
      st_strb: begin
        s_d.wr  = 1'b0;
        s_d.rd  = 1'b0;
        s_d.fsm = st_capt;
      end
      st_capt: begin
        if (s_q.rdop) begin
          s_d.rdata = link.data_bus;
        end
        s_d.fsm = s_q.ret;
      end
      st_irq1: begin
        if ((s_q.rdata & gpt_pkg::FIFO_VLD) != '0) begin
          s_d.last[4:0] = s_q.rdata[4:0];
          s_d = issue(s_d, 1'b0, {6'h00, s_q.rdata[4:0], gpt_pkg::OFF_STAT},
                      8'h00, st_irq2);
        end else begin
          s_d.fsm = st_idle;
        end
      end
      st_irq2: begin
        s_d.last[7] = s_q.rdata[gpt_pkg::B_TD];
        set[gpt_pkg::S_TONE] = 1'b1;
        s_d.fsm = st_idle;
      end
      st_man: begin
        set[gpt_pkg::S_ACC] = 1'b1;
        s_d.fsm = st_idle;
      end
      st_callw: begin
        s_d.cnt = s_q.cnt + 16'h0001;
        if (s_q.cnt == 16'(gpt_pkg::FRAME_CYC - 1)) begin
          s_d = issue(s_d, 1'b1, {6'h00, s_q.call_ch, gpt_pkg::OFF_CTRL1},
                      gpt_pkg::CTRL1_RUN, st_calle);
        end
      end
      st_calle: begin
        set[gpt_pkg::S_CALL] = 1'b1;
        s_d.fsm = st_idle;
      end
      default: s_d.fsm = st_idle;
    endcase

    // Sticky status: a new event wins over a write-one clear
    s_d.stat = (s_q.stat & ~w1c) | set;
    s_d.irq  = |(s_d.stat & s_q.mask);
  end

  // State register; the device is held in reset until a sequence runs
  always_ff @(posedge clk) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs
  assign link.reset_n = s_q.rst_n;
  assign link.addr    = s_q.la;
  assign link.wdata   = s_q.lw;
  assign link.wr      = s_q.wr;
  assign link.rd      = s_q.rd;
  assign sw_rdata     = s_q.swr;
  assign irq          = s_q.irq;
endmodule : gpt_host_ctl

// File: gpt_irq_fifo.sv
/*
  Interrupt FIFO of channel numbers, flip-flop storage.
  A push when full and a pop when empty are ignored by the flags.
*/
`timescale 1ns/1ps
module gpt_irq_fifo #(
  parameter int W     = 5,
  parameter int DEPTH = gpt_pkg::FIFO_DEPTH
) (
  input  logic         clk,
  input  logic         reset,
  input  logic         in_valid,
  output logic         in_ready,
  input  logic [W-1:0] in_data,
  output logic         out_valid,
  input  logic         out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
  } gpt_fifo_st_t;

  gpt_fifo_st_t s_q;
  gpt_fifo_st_t s_d;
  logic         push;
  logic         pop;

  // Flags and head entry
  assign in_ready  = s_q.cnt != (AW + 1)'(DEPTH);
  assign out_valid = s_q.cnt != '0;
  assign out_data  = s_q.mem[s_q.rp];
  assign push      = in_valid & in_ready;
  assign pop       = out_ready & out_valid;

  // Pointer and count update; a simultaneous push and pop keep the count
  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wp] = in_data;
      s_d.wp = (s_q.wp == AW'(DEPTH - 1)) ? '0 : s_q.wp + 1'b1;
    end
    if (pop) begin
      s_d.rp = (s_q.rp == AW'(DEPTH - 1)) ? '0 : s_q.rp + 1'b1;
    end
    s_d.cnt = s_q.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
  end

  // State register
  always_ff @(posedge clk) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule : gpt_irq_fifo

// File: gpt_link_if.sv
/*
  Parallel host link between the controller and the device.
  Assumes pull-ups on the interrupt and acknowledge wires.
*/
`timescale 1ns/1ps
interface gpt_link_if;
  logic        reset_n;
  logic [15:0] addr;
  logic [7:0]  wdata;
  logic        wr;
  logic        rd;
  logic [7:0]  dout;
  logic        dout_oe;
  logic        transfer_ack_out_n;
  logic        ack_oe;
  logic        irq_n_out;
  logic        irq_oe;
  logic [7:0]  data_bus;
  logic        irq_n;
  logic        transfer_ack_n;

  // Resolved wire levels: undriven data reads zero, pulled-up pins read high
  assign data_bus       = dout_oe ? dout : 8'h00;
  assign irq_n          = irq_oe ? irq_n_out : 1'b1;
  assign transfer_ack_n = ack_oe ? transfer_ack_out_n : 1'b1;

  modport dev (input reset_n, addr, wdata, wr, rd,
               output dout, dout_oe, transfer_ack_out_n, ack_oe, irq_n_out, irq_oe);
  modport host (output reset_n, addr, wdata, wr, rd,
                input data_bus, irq_n, transfer_ack_n);
endinterface : gpt_link_if

// File: gpt_link_sva.sv
/* Checker of the host link between controller and device.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
module gpt_link_sva (
  input logic        clk,
  input logic        reset,
  input logic        reset_n,
  input logic [15:0] addr,
  input logic        wr,
  input logic        rd,
  input logic [7:0]  data_bus,
  input logic        dout_oe,
  input logic        ack_oe,
  input logic        irq_oe,
  input logic        irq_n,
  input logic        transfer_ack_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // ----------------------------------------
  // Link properties
  // ----------------------------------------
  bus_ack_a: assert property ((wr || rd) |=> !transfer_ack_n) else $error("no ack");
  read_oe_a: assert property (rd |=> dout_oe) else $error("no read data");
  oe_cause_a: assert property (dout_oe |-> $past(rd)) else $error("stray drive");
  fifo_irq_a: assert property ((rd && addr == 16'h0410) |=> irq_n)
    else $error("irq low");
  fifo_val_a: assert property (
    (rd && addr == 16'h0410) |=> (data_bus == 8'h00 || data_bus[7])) else $error("bad entry");
  unmap_zero_a: assert property ((rd && addr > 16'h0411) |=> data_bus == 8'h00)
    else $error("unmapped data");
  test_zero_a: assert property ((rd && addr == 16'h0411) |=> data_bus == 8'h00)
    else $error("test reg set");
  rst_float_a: assert property (!reset_n |=> !(dout_oe || ack_oe || irq_oe))
    else $error("driven in reset");
endmodule : gpt_link_sva

// File: gpt_pkg.sv
/*
  Shared constants for the group power and tone interrupt control pair:
  link address map, field positions, reset values and timing counts.
  Assumes a single 20 MHz clock on both ends.
*/
// Behaviour
// - Host holds device reset low 100 us
// - Device in reset: outputs undriven, logic idle
// - Reset zeroes main, FIFO and test registers
// - Host waits 500 us for lock
// - Host powers each group by power bit
// - Power bit rise: defaults loaded, coefficients cleared
// - Init takes two frames; group writes wait
// - Power bit low: PCM bypassed, two-frame delay
// - Call init: bypass one frame, then adapt
// - Reset cancellers before call progress tones
// - Tone detect and release each raise events
// - Events queued with channel; read returns it
// - Interrupt pin high after each FIFO read
// - Interrupt pin low again per pending entry
// - Host reads FIFO then channel status
// - Global mask bit blocks all interrupts
// - Per-group mask bits for cancellers A, B
// - Channel, main, FIFO registers address mapped
package gpt_pkg;

  // ----------------------------------------------------------------
  // Sizes and timing
  // ----------------------------------------------------------------
  localparam int N_GRP         = 16;
  localparam int N_CH          = 32;
  localparam int FIFO_DEPTH    = 2 * N_CH;
  localparam int CLK_NS        = 50;
  localparam int RST_HOLD_US   = 100;
  localparam int PLL_WAIT_US   = 500;
  localparam int FRAME_US      = 125;
  localparam int INIT_FRAMES   = 2;
  localparam int RST_HOLD_CYC  = (RST_HOLD_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int PLL_WAIT_CYC  = (PLL_WAIT_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int FRAME_CYC     = (FRAME_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int INIT_WAIT_CYC = (INIT_FRAMES + 1) * FRAME_CYC;

  // ----------------------------------------------------------------
  // Device address map and fields
  // ----------------------------------------------------------------
  localparam logic [15:0] A_MAIN    = 16'h0400;
  localparam logic [15:0] A_FIFO    = 16'h0410;
  localparam logic [15:0] A_TEST    = 16'h0411;
  localparam logic [4:0]  OFF_CTRL1 = 5'h00;
  localparam logic [4:0]  OFF_CTRL2 = 5'h01;
  localparam logic [4:0]  OFF_STAT  = 5'h02;
  localparam int          B_GROUP_POWER_UP_BIT    = 0;
  localparam int          B_MASK_A  = 3;
  localparam int          B_MASK_B  = 4;
  localparam int          B_GMASK   = 5;
  localparam int          B_TD      = 0;
  localparam logic [7:0]  CTRL1_DEF = 8'h00;
  localparam logic [7:0]  CTRL2_DEF = 8'h00;
  localparam logic [7:0]  CTRL1_BYP = 8'h01;
  localparam logic [7:0]  CTRL1_RUN = 8'h00;
  localparam logic [7:0]  FIFO_VLD  = 8'h80;

  // ----------------------------------------------------------------
  // Host controller software registers
  // ----------------------------------------------------------------
  localparam logic [3:0] H_CTRL   = 4'h0;
  localparam logic [3:0] H_GROUPS = 4'h1;
  localparam logic [3:0] H_ADDR   = 4'h2;
  localparam logic [3:0] H_WDATA  = 4'h3;
  localparam logic [3:0] H_RDATA  = 4'h4;
  localparam logic [3:0] H_STAT   = 4'h5;
  localparam logic [3:0] H_MASK   = 4'h6;
  localparam logic [3:0] H_LAST   = 4'h7;
  localparam logic [3:0] H_CALL   = 4'h8;
  localparam logic [3:0] H_STATE  = 4'h9;
  localparam int C_SEQ  = 0;
  localparam int C_RD   = 1;
  localparam int C_WR   = 2;
  localparam int C_CALL = 3;
  localparam int S_SEQ  = 0;
  localparam int S_TONE = 1;
  localparam int S_ACC  = 2;
  localparam int S_CALL = 3;

endpackage : gpt_pkg

// File: gpt_test.sv
/* Testbench of the controller-device pair through the software port.
   Assumes shortened lock, init and frame counts. */
`timescale 1ns/1ps
module test_group_power_and_tone_irq_ctrl;
  logic clk = 0, reset = 1, sw_wr = 0, sw_rd = 0, irq, pcm_valid = 0;
  logic [3:0]  sw_addr = 4'h0;
  logic [15:0] sw_wdata = 16'h0000, sw_rdata;
  logic [31:0] tone = 32'h0;
  logic [7:0]  smp = 8'h5a;
  int errors = 0, check_count = 0;
  gpt_link_if link();
  gpt_evp_dev #(.FRAME_CYC(16)) gpt_evp_dev_inst (.clk(clk), .reset(reset), .link(link),
    .tone_detect(tone), .pcm_valid(pcm_valid), .pcm_chan(smp[4:0]), .rin_in(smp),
    .sin_in(smp), .proc_rout(smp), .proc_sout(smp), .rout(), .sout(), .pcm_out_valid(),
    .pcm_out_en(), .group_active(), .coef_clear());
  gpt_host_ctl #(.PLL_WAIT_CYC(20), .INIT_WAIT_CYC(40)) gpt_host_ctl_inst (.clk(clk),
    .reset(reset), .link(link), .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr),
    .sw_rd(sw_rd), .sw_rdata(sw_rdata), .irq(irq));
  gpt_link_sva gpt_link_sva_inst (.clk(clk), .reset(reset), .reset_n(link.reset_n),
    .addr(link.addr), .wr(link.wr), .rd(link.rd), .data_bus(link.data_bus),
    .dout_oe(link.dout_oe), .ack_oe(link.ack_oe), .irq_oe(link.irq_oe), .irq_n(link.irq_n),
    .transfer_ack_n(link.transfer_ack_n));
  initial begin
    forever #25 clk = ~clk;
  end
  task end_of_test;
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test
  task chk(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk) {sw_addr, sw_wdata, sw_wr} <= {a, d, 1'b1};
    @(posedge clk) sw_wr <= 1'b0;
  endtask : wr
  task rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk) {sw_addr, sw_rd} <= {a, 1'b1};
    @(posedge clk) sw_rd <= 1'b0;
    @(negedge clk) chk(sw_rdata, e);
  endtask : rd
  // Wait for the interrupt, then clear the status bit given
  task wirq(input logic [15:0] b);
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 20000) begin
      @(negedge clk);
      n++;
    end
    chk({15'h0, irq}, 16'h1);
    rd(gpt_pkg::H_STAT, b);
    wr(gpt_pkg::H_STAT, b);
  endtask : wirq
  task acc(input logic [15:0] a, input logic [15:0] d, input logic [15:0] c);
    wr(gpt_pkg::H_ADDR, a);
    wr(gpt_pkg::H_WDATA, d);
    wr(gpt_pkg::H_CTRL, c);
    wirq(16'h0004);
  endtask : acc
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    wr(gpt_pkg::H_MASK, 16'h000f);
    wr(gpt_pkg::H_GROUPS, 16'h0001);
    wr(gpt_pkg::H_CTRL, 16'h0001);
    wirq(16'h0001);
    acc(16'h0400, 0, 2); rd(gpt_pkg::H_RDATA, 16'h0001);
    acc(16'h0000, 0, 2); rd(gpt_pkg::H_RDATA, 16'h0000);
    acc(16'h0410, 0, 2); rd(gpt_pkg::H_RDATA, 16'h0000);
    acc(16'h0411, 0, 2); rd(gpt_pkg::H_RDATA, 16'h0000);
    acc(16'h0500, 0, 2); rd(gpt_pkg::H_RDATA, 16'h0000);
    // Manual write lands, then call init puts the control back to run
    acc(16'h0020, 16'h0055, 4);
    acc(16'h0020, 0, 2);
    rd(gpt_pkg::H_RDATA, 16'h0055);
    wr(gpt_pkg::H_CALL, 16'h0001);
    wr(gpt_pkg::H_CTRL, 16'h0008);
    wirq(16'h0008);
    acc(16'h0020, 0, 2);
    rd(gpt_pkg::H_RDATA, 16'h0000);
    @(posedge clk) tone <= 32'h2;
    wirq(16'h0002); rd(gpt_pkg::H_LAST, 16'h0081);
    @(posedge clk) tone <= 32'h0;
    wirq(16'h0002); rd(gpt_pkg::H_LAST, 16'h0001);
    acc(16'h0400, 16'h0021, 4);
    @(posedge clk) tone <= 32'h1;
    repeat (200) @(posedge clk);
    chk({15'h0, irq}, 16'h0);
    acc(16'h0410, 0, 2);
    rd(gpt_pkg::H_RDATA, 16'h0000);
    // Canceller A masked: its release must not queue or reach the host
    acc(16'h0400, 16'h0009, 4);
    @(posedge clk) tone <= 32'h0;
    repeat (50) @(posedge clk);
    acc(16'h0410, 0, 2);
    rd(gpt_pkg::H_RDATA, 16'h0000);
    end_of_test();
  end
  initial begin
    #2000000;
    errors++;
    end_of_test();
  end
endmodule : test_group_power_and_tone_irq_ctrl
